// ### bench/acg_host.sv
// serial host model: chip select, serial clock and data out, returned bits in
// assumes the 40 ns mclk; sclk period 320 ns, idle low, frames up to 32 bits
module acg_host (
   input wire mclk,
   output logic cs_n,
   output logic sclk,
   output logic din,
   input wire dout
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cs_n = 1'h1;
      sclk = 1'h0;
      din = 1'h0;
   end
   // msb first; dout is taken mid high phase, well after the design moved it
   task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = 32'h0;
      @(posedge mclk);
      cs_n <= 1'h0;
      for (int i = n - 1; i >= 0; i--)
      begin
         din <= tx[i];
         repeat (4) @(posedge mclk);
         sclk <= 1'h1;
         repeat (2) @(posedge mclk);
         rx = {rx[30:0], dout};
         repeat (2) @(posedge mclk);
         sclk <= 1'h0;
      end
      repeat (4) @(posedge mclk);
      cs_n <= 1'h1;
      // a released data line must not look like a held bit
      din <= ~tx[0];
      repeat (4) @(posedge mclk);
      #1;
   endtask
endmodule

// ### bench/acg_monitor.sv
// checker: pacing, reset levels, register-held outputs, calibration phases
// assumes binding into acg_core; mclk rising edge, rstn async active low
module acg_monitor #(
   parameter [31:0] SELF_CAL_CYC = 32'd5000000
)(
   input wire mclk,
   input wire rstn,
   input wire cs_n,
   input wire mod_en,
   input wire [3:0] gpio_out,
   input wire [3:0] gpio_oe,
   input wire osc_2048_sel,
   input wire ref_buffer_enable,
   input wire signal_buffer_enable,
   input wire cal_zero_conn,
   input wire cal_fs_conn
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int HALF = SELF_CAL_CYC / 2;
   logic [31:0] gap_q, zc_q, fc_q;
   logic seen_q, sel_q;
   // the first gap after reset is partial, so pacing waits for one pulse
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         {gap_q, zc_q, fc_q, seen_q, sel_q} <= 98'h0;
      else
      begin
         gap_q <= mod_en ? 32'h0 : gap_q + 32'h1;
         zc_q <= cal_zero_conn ? zc_q + 32'h1 : 32'h0;
         fc_q <= cal_fs_conn ? fc_q + 32'h1 : 32'h0;
         seen_q <= seen_q | mod_en;
         sel_q <= mod_en ? osc_2048_sel : sel_q;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   property p_pace;
      mod_en && seen_q && sel_q == osc_2048_sel |-> gap_q >= (osc_2048_sel ? 32'h79 : 32'h64);
   endproperty
   a_pace: assert property (p_pace) else $error("mod_en too soon");
   property p_rst;
      $rose(rstn) |-> !osc_2048_sel && !ref_buffer_enable && !signal_buffer_enable && {gpio_oe, gpio_out} == 8'h0;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not at reset levels");
   property p_gpio;
      cs_n [*8] |-> $stable({gpio_oe, gpio_out});
   endproperty
   a_gpio: assert property (p_gpio) else $error("gpio changed with no frame");
   property p_buf;
      cs_n [*8] |-> $stable({osc_2048_sel, ref_buffer_enable, signal_buffer_enable});
   endproperty
   a_buf: assert property (p_buf) else $error("control level changed with no frame");
   property p_excl;
      !(cal_zero_conn && cal_fs_conn);
   endproperty
   a_excl: assert property (p_excl) else $error("both cal phases on");
   property p_zlen;
      $fell(cal_zero_conn) && cs_n |-> zc_q >= HALF - 1 && zc_q <= HALF + 1;
   endproperty
   a_zlen: assert property (p_zlen) else $error("zero phase length wrong");
   property p_zfs;
      $fell(cal_zero_conn) && cs_n |-> cal_fs_conn;
   endproperty
   a_zfs: assert property (p_zfs) else $error("full phase did not follow zero phase");
   property p_flen;
      $fell(cal_fs_conn) && cs_n |-> fc_q >= HALF - 1 && fc_q <= HALF + 1;
   endproperty
   a_flen: assert property (p_flen) else $error("full phase length wrong");
endmodule
bind acg_core acg_monitor #(.SELF_CAL_CYC(SELF_CAL_CYC)) acg_monitor_inst (
   .mclk(mclk), .rstn(rstn), .cs_n(cs_n), .mod_en(mod_en), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
   .osc_2048_sel(osc_2048_sel), .ref_buffer_enable(ref_buffer_enable),
   .signal_buffer_enable(signal_buffer_enable), .cal_zero_conn(cal_zero_conn), .cal_fs_conn(cal_fs_conn)
);

// ### bench/tb.sv
// self-checking bench for the converter control block through its serial port
// assumes acg_core with shortened calibration counts and acg_host as serial host
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [31:0] SELF_CYC = 32'h0fa0;
   localparam [31:0] SYS_CYC = 32'h07d0;
   logic mclk, rstn, cs_n, sclk, din, dout, mod_bit, mod_en;
   logic osc_2048_sel, ref_buffer_enable, signal_buffer_enable, cal_zero_conn, cal_fs_conn, power_down, dout_oe;
   logic [3:0] gpio_in, gpio_out, gpio_oe;
   int n_mismatch = 0;
   int comparisons = 0;
   acg_core #(.SELF_CAL_CYC(SELF_CYC), .SYS_CAL_CYC(SYS_CYC)) acg_core_inst (
      .mclk(mclk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
      .mod_bit(mod_bit), .mod_en(mod_en), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
      .osc_2048_sel(osc_2048_sel), .ref_buffer_enable(ref_buffer_enable), .power_down(power_down),
      .signal_buffer_enable(signal_buffer_enable), .cal_zero_conn(cal_zero_conn), .cal_fs_conn(cal_fs_conn)
   );
   acg_host acg_host_inst (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
   initial
   begin
      mclk = 1'h0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk)
      if (mod_en === 1'h1)
         mod_bit <= ~mod_bit;
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic xf(input logic [7:0] c, input logic [23:0] d, input int nb, output logic [23:0] v);
      logic [31:0] r;
      acg_host_inst.xfer(({24'h0, c} << nb) | {8'h0, d}, 8 + nb, r);
      v = r[23:0] & ((24'h1 << nb) - 24'h1);
   endtask
   task automatic gap(input logic [23:0] exp);
      int t;
      repeat (2)
      begin
         t = 0;
         do
         begin
            @(posedge mclk);
            #1;
            t++;
         end
         while (mod_en !== 1'h1 && t < 300);
      end
      chk("mod_en spacing", 24'(t), exp);
   endtask
   task automatic t_reset;
      logic [23:0] v;
      for (int s = 5; s <= 8; s++)
      begin
         xf({3'h6, 4'(s), 1'h1}, 24'h0, 24, v);
         chk("correction reset", v, 24'h0);
      end
      xf(8'hc7, 24'h0, 8, v);
      chk("disable bits reset", v, 24'h1e);
      xf(8'hc5, 24'h0, 8, v);
      chk("io reset", v, {20'h0, gpio_in});
      $display("reset values done");
   endtask
   task automatic t_ctrl;
      logic [23:0] v;
      xf(8'hc2, 24'h12, 8, v);
      chk("ref on sig off", {22'h0, ref_buffer_enable, signal_buffer_enable}, 24'h2);
      xf(8'hc2, 24'h0a, 8, v);
      chk("ref off sig on", {22'h0, ref_buffer_enable, signal_buffer_enable}, 24'h1);
      xf(8'hc3, 24'h0, 8, v);
      chk("ctrl readback", v, 24'h0a);
      gap(24'h65);
      xf(8'hc2, 24'h8a, 8, v);
      chk("osc select", {23'h0, osc_2048_sel}, 24'h1);
      gap(24'h7a);
      $display("control bits done");
   endtask
   task automatic t_gpio;
      logic [23:0] v;
      logic [7:0] p [4] = '{8'hf1, 8'hf0, 8'hf4, 8'h31};
      for (int i = 0; i < 4; i++)
      begin
         xf(8'hc4, {16'h0, p[i]}, 8, v);
         chk("gpio pins", {16'h0, gpio_oe, gpio_out}, {16'h0, p[i]});
      end
      xf(8'hc5, 24'h0, 8, v);
      chk("io mixed readback", v, {16'h0, 4'h3, gpio_in[3:2], 2'h1});
      $display("gpio done");
   endtask
   task automatic t_self;
      logic [23:0] v;
      xf(8'hc6, 24'h18, 8, v);
      xf(8'h90, 24'h0, 0, v);
      chk("zero phase", {23'h0, cal_zero_conn}, 24'h1);
      xf(8'hc1, 24'h0, 8, v);
      chk("status in cal", v & 24'h9, 24'h8);
      repeat (SELF_CYC / 2) @(posedge mclk);
      #1;
      chk("full phase", {23'h0, cal_fs_conn}, 24'h1);
      repeat (SELF_CYC / 2 + 400) @(posedge mclk);
      xf(8'hd1, 24'h0, 24, v);
      chk("self gain written", {23'h0, v != 24'h0}, 24'h1);
      $display("self calibration done");
   endtask
   task automatic t_sys;
      logic [23:0] v;
      for (int i = 0; i < 2; i++)
      begin
         xf(i ? 8'hb0 : 8'ha0, 24'h0, 0, v);
         repeat (SYS_CYC / 2 - 150) @(posedge mclk);
         xf(8'hc1, 24'h0, 8, v);
         chk("system cal busy", v & 24'h9, 24'h8);
         repeat (SYS_CYC / 2 + 100) @(posedge mclk);
         xf(8'hc1, 24'h0, 8, v);
         chk("system cal over", v & 24'h8, 24'h0);
      end
      xf(8'hcd, 24'h0, 24, v);
      chk("system gain written", {23'h0, v != 24'h0}, 24'h1);
      xf(8'h88, 24'h0, 0, v);
      chk("power down", {23'h0, power_down}, 24'h1);
      xf(8'h87, 24'h0, 0, v);
      xf(8'hc1, 24'h0, 8, v);
      chk("rate in status", v, 24'h74);
      chk("pins released", {22'h0, power_down, dout_oe}, 24'h0);
      $display("system calibration done");
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge mclk);
      n_mismatch++;
      wrap_up();
   end
   initial
   begin
      rstn = 1'h0;
      gpio_in = 4'ha;
      mod_bit = 1'h0;
      repeat (20) @(posedge mclk);
      rstn <= 1'h1;
      repeat (3) @(posedge mclk);
      t_reset();
      t_ctrl();
      t_gpio();
      t_self();
      t_sys();
      wrap_up();
   end
endmodule

// ### hdl/acg_consts.vh
// constants for the converter control block: timing, register selects, field positions, reset values
// assumes a 25 MHz mclk; included by bare name from every design file
`ifndef ACG_CONSTS_VH
`define ACG_CONSTS_VH
`define ACG_MCLK_HZ 25000000
`define ACG_OSC60_HZ 2457600
`define ACG_OSC50_HZ 2048000
`define ACG_MOD_DIV60 ((`ACG_MCLK_HZ*10)/`ACG_OSC60_HZ)
`define ACG_MOD_DIV50 ((`ACG_MCLK_HZ*10)/`ACG_OSC50_HZ)
`define ACG_SELF_CAL_MS 200
`define ACG_SYS_CAL_MS 100
`define ACG_SELF_CAL_CYC (`ACG_SELF_CAL_MS*(`ACG_MCLK_HZ/1000))
`define ACG_SYS_CAL_CYC (`ACG_SYS_CAL_MS*(`ACG_MCLK_HZ/1000))
`define ACG_RS_STAT 4'h0
`define ACG_RS_CFG 4'h1
`define ACG_RS_IO 4'h2
`define ACG_RS_CORCFG 4'h3
`define ACG_RS_DATA 4'h4
`define ACG_RS_OFF_SYS 4'h5
`define ACG_RS_GAIN_SYS 4'h6
`define ACG_RS_OFF_SELF 4'h7
`define ACG_RS_GAIN_SELF 4'h8
`define ACG_C1_LINE 7
`define ACG_C1_REFB 4
`define ACG_C1_SIGB 3
`define ACG_C1_SINGLE 1
`define ACG_C3_GSYS_DIS 4
`define ACG_C3_OSYS_DIS 3
`define ACG_C3_GSELF_DIS 2
`define ACG_C3_OSELF_DIS 1
`define ACG_CFG_RST 8'h02
`define ACG_IO_RST 8'h00
`define ACG_CORCFG_RST 8'h1e
`define ACG_CORR_RST 24'h000000
`define ACG_CMD_START 7
`define ACG_CMD_MODE 6
`define ACG_CMD_IMPD 3
`define ACG_CAL_NONE 2'h0
`define ACG_CAL_SELF 2'h1
`define ACG_CAL_SYSZ 2'h2
`define ACG_CAL_SYSF 2'h3
`define ACG_FS_CODE 24'h7fffff
`define ACG_GAIN_HALF 25'h0800000
`define ACG_CAL_DEC 16'h0200
`define ACG_CAL_SHIFT 7'd13
`endif

// ### hdl/acg_core.v
// converter control: serial command port, control registers, conversion sequencing, calibration, gpio
// assumes a 25 MHz mclk, pins asynchronous to it, mod_bit produced on mclk at each mod_en pulse
//
// Contract
// - oscillator 2.4576 or 2.048 MHz by line select
// - reference buffer follows its first-register enable
// - reference and signal buffers switch independently
// - correction registers reset to zero
// - disable bits reset high, block their correction
// - uncorrected full-scale input gives about sixty percent
// - offset correction in half-lsb steps, quarter reference
// - gain correction factor from half to one-and-half
// - self calibration 200ms, writes self registers
// - system zero calibration 100ms, writes system offset
// - system full-scale calibration 100ms, writes system gain
// - rate bits with line select pick rate
// - single-cycle bit selects single or continuous
// - single-cycle results settled, up to 120/100sps
// - continuous rate four times single-cycle rate
// - continuous mode: three unsettled results after step
// - sinc4 filter, nulls at output rate multiples
// - io register: high nibble direction, low levels
`include "acg_consts.vh"
module acg_core #(
   parameter [31:0] SELF_CAL_CYC = `ACG_SELF_CAL_CYC,
   parameter [31:0] SYS_CAL_CYC = `ACG_SYS_CAL_CYC
)(
   input wire mclk,
   input wire rstn,
   input wire cs_n,
   input wire sclk,
   input wire din,
   output reg dout,
   output wire dout_oe,
   input wire mod_bit,
   output reg mod_en,
   input wire [3:0] gpio_in,
   output wire [3:0] gpio_out,
   output wire [3:0] gpio_oe,
   output wire osc_2048_sel,
   output wire ref_buffer_enable,
   output wire signal_buffer_enable,
   output reg power_down,
   output wire cal_zero_conn,
   output wire cal_fs_conn
);
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_CONV = 5'h02;
   localparam [4:0] ST_CALZ = 5'h04;
   localparam [4:0] ST_CALF = 5'h08;
   localparam [4:0] ST_GDIV = 5'h10;
   localparam signed [65:0] POS_LIM = 66'sh7fffff;
   localparam signed [65:0] NEG_LIM = -66'sh800000;

   // pin synchronisers: {gpio_in, din, sclk, cs_n}
   reg [6:0] sync1_q;
   reg [6:0] sync2_q;
   reg sclk_d_q;
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_q <= 7'h01;
         sync2_q <= 7'h01;
         sclk_d_q <= 1'b0;
      end
      else
      begin
         sync1_q <= {gpio_in, din, sclk, cs_n};
         sync2_q <= sync1_q;
         sclk_d_q <= sync2_q[1];
      end
   end
   wire cs_act = ~sync2_q[0];
   wire din_s = sync2_q[2];
   wire [3:0] gpio_s = sync2_q[6:3];
   wire rise = cs_act & sync2_q[1] & ~sclk_d_q;
   wire fall = cs_act & ~sync2_q[1] & sclk_d_q;

   reg [7:0] cfg_q;
   reg [7:0] io_q;
   reg [7:0] corcfg_q;
   reg [23:0] off_self_q;
   reg [23:0] gain_self_q;
   reg [23:0] off_sys_q;
   reg [23:0] gain_sys_q;
   reg [23:0] data_q;
   reg rdy_q;
   reg [2:0] rate_q;
   reg [4:0] st_q;

   // serial port
   reg [5:0] bit_q;
   reg [23:0] sh_q;
   reg [23:0] tx_q;
   reg acc_q;
   reg done_q;
   reg rd_q;
   reg [3:0] rs_q;
   reg rd_arm_q;
   reg rd_act_q;
   reg cmd_v_q;
   reg [7:0] cmd_b_q;
   reg wr_v_q;
   reg [3:0] wr_rs_q;
   reg [23:0] wr_d_q;
   reg data_rd_q;
   reg [23:0] rd_val;
   wire [23:0] nb = {sh_q[22:0], din_s};
   wire [3:0] nrs = nb[4:1];
   wire [5:0] last_bit = (rs_q == `ACG_RS_DATA) | rs_q[3] | (rs_q[2] & (rs_q[1] | rs_q[0])) ? 6'd31 : 6'd15;
   wire calb = st_q[2] | st_q[3] | st_q[4];

   always @*
   begin
      case (nrs)
         `ACG_RS_STAT: rd_val = {1'b0, rate_q, calb, ~st_q[0], 1'b0, rdy_q, 16'h0000};
         `ACG_RS_CFG: rd_val = {cfg_q, 16'h0000};
         `ACG_RS_IO: rd_val = {io_q[7:4], (io_q[7:4] & io_q[3:0]) | (~io_q[7:4] & gpio_s), 16'h0000};
         `ACG_RS_CORCFG: rd_val = {corcfg_q, 16'h0000};
         `ACG_RS_DATA: rd_val = data_q;
         `ACG_RS_OFF_SYS: rd_val = off_sys_q;
         `ACG_RS_GAIN_SYS: rd_val = gain_sys_q;
         `ACG_RS_OFF_SELF: rd_val = off_self_q;
         `ACG_RS_GAIN_SELF: rd_val = gain_self_q;
         default: rd_val = 24'h000000;
      endcase
   end

   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         bit_q <= 6'h00; sh_q <= 24'h000000; tx_q <= 24'h000000;
         acc_q <= 1'b0; done_q <= 1'b0; rd_q <= 1'b0; rs_q <= 4'h0;
         rd_arm_q <= 1'b0; rd_act_q <= 1'b0; cmd_v_q <= 1'b0; cmd_b_q <= 8'h00;
         wr_v_q <= 1'b0; wr_rs_q <= 4'h0; wr_d_q <= 24'h000000; data_rd_q <= 1'b0;
         dout <= 1'b1;
      end
      else
      begin
         cmd_v_q <= 1'b0;
         wr_v_q <= 1'b0;
         data_rd_q <= 1'b0;
         dout <= rd_act_q ? tx_q[23] : ~rdy_q;
         if (!cs_act)
         begin
            bit_q <= 6'h00; acc_q <= 1'b0; done_q <= 1'b0;
            rd_arm_q <= 1'b0; rd_act_q <= 1'b0;
         end
         else if (rise & ~done_q)
         begin
            sh_q <= nb;
            bit_q <= bit_q + 1'b1;
            if (bit_q == 6'd7)
            begin
               if (!nb[`ACG_CMD_START])
                  done_q <= 1'b1;
               else if (!nb[`ACG_CMD_MODE])
               begin
                  cmd_v_q <= 1'b1;
                  cmd_b_q <= nb[7:0];
                  done_q <= 1'b1;
               end
               else
               begin
                  acc_q <= 1'b1; rs_q <= nrs; rd_q <= nb[0];
                  if (nb[0])
                  begin
                     tx_q <= rd_val;
                     rd_arm_q <= 1'b1;
                  end
               end
            end
            else if (acc_q & (bit_q == last_bit))
            begin
               done_q <= 1'b1;
               if (!rd_q)
               begin
                  wr_v_q <= 1'b1; wr_rs_q <= rs_q; wr_d_q <= nb;
               end
               else if (rs_q == `ACG_RS_DATA)
                  data_rd_q <= 1'b1;
            end
         end
         else if (fall)
         begin
            if (rd_arm_q)
            begin
               rd_arm_q <= 1'b0; rd_act_q <= 1'b1;
            end
            else if (rd_act_q)
               tx_q <= {tx_q[22:0], 1'b0};
         end
      end
   end
   assign dout_oe = cs_act;

   // control registers
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         cfg_q <= `ACG_CFG_RST;
         io_q <= `ACG_IO_RST;
         corcfg_q <= `ACG_CORCFG_RST;
      end
      else if (wr_v_q)
      begin
         if (wr_rs_q == `ACG_RS_CFG)
            cfg_q <= wr_d_q[7:0];
         if (wr_rs_q == `ACG_RS_IO)
            io_q <= wr_d_q[7:0];
         if (wr_rs_q == `ACG_RS_CORCFG)
            corcfg_q <= wr_d_q[7:0];
      end
   end
   assign gpio_oe = io_q[7:4];
   assign gpio_out = io_q[3:0];
   assign osc_2048_sel = cfg_q[`ACG_C1_LINE];
   assign ref_buffer_enable = cfg_q[`ACG_C1_REFB];
   assign signal_buffer_enable = cfg_q[`ACG_C1_SIGB];

   // modulator sample enable at a tenth of the selected oscillator rate
   reg [7:0] mod_cnt_q;
   wire [7:0] mod_lim = cfg_q[`ACG_C1_LINE] ? 8'd121 : 8'd100;
   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         mod_cnt_q <= 8'h00;
         mod_en <= 1'b0;
      end
      else
      begin
         mod_en <= (mod_cnt_q == mod_lim);
         mod_cnt_q <= (mod_cnt_q >= mod_lim) ? 8'h00 : mod_cnt_q + 1'b1;
      end
   end

   // decimation per rate code; single-cycle delivers every fourth output
   function [15:0] dec_of;
      input [2:0] r;
      case (r)
         3'h0: dec_of = 16'hf000;
         3'h1: dec_of = 16'h6000;
         3'h2: dec_of = 16'h3000;
         3'h3: dec_of = 16'h1800;
         3'h4: dec_of = 16'h1000;
         3'h5: dec_of = 16'h0800;
         3'h6: dec_of = 16'h0400;
         default: dec_of = 16'h0200;
      endcase
   endfunction
   // shift of 4*ceil(log2 dec)-23; non power-of-two ratios lose gain, down to (3/4)^4 at 0x6000, 0x3000 and 0x1800
   function [6:0] sh_of;
      input [2:0] r;
      case (r)
         3'h0: sh_of = 7'd41;
         3'h1: sh_of = 7'd37;
         3'h2: sh_of = 7'd33;
         3'h3: sh_of = 7'd29;
         3'h4: sh_of = 7'd25;
         3'h5: sh_of = 7'd21;
         3'h6: sh_of = 7'd17;
         default: sh_of = 7'd13;
      endcase
   endfunction
   function [23:0] sat24;
      input signed [65:0] v;
      if (v > POS_LIM)
         sat24 = 24'h7fffff;
      else if (v < NEG_LIM)
         sat24 = 24'h800000;
      else
         sat24 = v[23:0];
   endfunction

   reg filt_clr_q;
   wire filt_v;
   wire signed [65:0] filt_val;
   wire [15:0] dec_sel = calb ? `ACG_CAL_DEC : dec_of(rate_q);
   wire [6:0] sh_sel = calb ? `ACG_CAL_SHIFT : sh_of(rate_q);
   acg_sinc4 #(.ACC_W(66), .DEC_W(16)) u_filt (
      .mclk(mclk),
      .rstn(rstn),
      .clr(filt_clr_q),
      .in_en(mod_en),
      .in_bit(mod_bit),
      .dec(dec_sel),
      .out_valid(filt_v),
      .out_val(filt_val)
   );
   // front end gives 60% density at full scale, so raw full scale lands near 60%
   wire [23:0] raw = sat24(filt_val >>> sh_sel);

   // correction: offsets in half-lsb units first, then self gain, then system gain
   wire signed [26:0] h0 = {raw[23], raw[23], raw, 1'b0};
   wire signed [26:0] o1 = corcfg_q[`ACG_C3_OSELF_DIS] ? 27'sh0 : {{3{off_self_q[23]}}, off_self_q};
   wire signed [26:0] o2 = corcfg_q[`ACG_C3_OSYS_DIS] ? 27'sh0 : {{3{off_sys_q[23]}}, off_sys_q};
   wire signed [26:0] h1 = h0 - o1 - o2;
   wire [24:0] g1 = `ACG_GAIN_HALF + {1'b0, gain_self_q};
   wire [24:0] g2 = `ACG_GAIN_HALF + {1'b0, gain_sys_q};
   wire signed [52:0] p1 = h1 * $signed({1'b0, g1});
   wire signed [26:0] h2 = corcfg_q[`ACG_C3_GSELF_DIS] ? h1 : p1[50:24];
   wire signed [52:0] p2 = h2 * $signed({1'b0, g2});
   wire signed [26:0] h3 = corcfg_q[`ACG_C3_GSYS_DIS] ? h2 : p2[50:24];
   wire signed [65:0] hy = {{40{h3[26]}}, h3[26:1]};
   wire [23:0] corr = sat24(hy);

   // sequencer
   reg [1:0] kind_q;
   reg [31:0] tmr_q;
   reg [1:0] nout_q;
   reg [23:0] last_q;
   reg [23:0] moff_q;
   reg [23:0] m_q;
   reg [47:0] dq_q;
   reg [24:0] rem_q;
   reg [5:0] dcnt_q;
   wire [1:0] ccal = cmd_b_q[5:4];
   wire [24:0] dt = {rem_q[23:0], dq_q[47]};
   wire dge = (dt >= {1'b0, m_q});
   wire [47:0] qfin = {dq_q[46:0], dge};
   wire [23:0] mdiff = last_q - ((kind_q == `ACG_CAL_SELF) ? moff_q : 24'h000000);
   wire [23:0] gsat = (qfin < 48'h800000) ? 24'h000000 : (qfin >= 48'h1800000) ? 24'hffffff : qfin[23:0] - 24'h800000;

   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_q <= ST_IDLE; kind_q <= `ACG_CAL_NONE; tmr_q <= 32'h0; nout_q <= 2'h0;
         rate_q <= 3'h0; rdy_q <= 1'b0; data_q <= 24'h000000; filt_clr_q <= 1'b0;
         last_q <= 24'h000000; moff_q <= 24'h000000; m_q <= 24'h000001;
         dq_q <= 48'h0; rem_q <= 25'h0; dcnt_q <= 6'h00; power_down <= 1'b0;
         off_self_q <= `ACG_CORR_RST; gain_self_q <= `ACG_CORR_RST;
         off_sys_q <= `ACG_CORR_RST; gain_sys_q <= `ACG_CORR_RST;
      end
      else
      begin
         filt_clr_q <= 1'b0;
         if (data_rd_q)
            rdy_q <= 1'b0;
         if (wr_v_q)
         begin
            if (wr_rs_q == `ACG_RS_OFF_SELF) off_self_q <= wr_d_q;
            if (wr_rs_q == `ACG_RS_GAIN_SELF) gain_self_q <= wr_d_q;
            if (wr_rs_q == `ACG_RS_OFF_SYS) off_sys_q <= wr_d_q;
            if (wr_rs_q == `ACG_RS_GAIN_SYS) gain_sys_q <= wr_d_q;
         end
         if (cmd_v_q)
         begin
            filt_clr_q <= 1'b1;
            nout_q <= 2'h0;
            power_down <= cmd_b_q[`ACG_CMD_IMPD];
            if (cmd_b_q[`ACG_CMD_IMPD])
               st_q <= ST_IDLE;
            else if (ccal != `ACG_CAL_NONE)
            begin
               kind_q <= ccal;
               rdy_q <= 1'b0;
               st_q <= (ccal == `ACG_CAL_SYSF) ? ST_CALF : ST_CALZ;
               tmr_q <= (ccal == `ACG_CAL_SELF) ? (SELF_CAL_CYC >> 1) - 1 : SYS_CAL_CYC - 1;
            end
            else
            begin
               rate_q <= cmd_b_q[2:0];
               st_q <= ST_CONV;
            end
         end
         else
         begin
            case (st_q)
               ST_IDLE: st_q <= ST_IDLE;
               ST_CONV:
                  if (filt_v)
                  begin
                     if (cfg_q[`ACG_C1_SINGLE])
                     begin
                        nout_q <= nout_q + 1'b1;
                        if (nout_q == 2'h3)
                        begin
                           data_q <= corr;
                           rdy_q <= 1'b1;
                           st_q <= ST_IDLE;
                        end
                     end
                     else
                     begin
                        data_q <= corr;
                        rdy_q <= 1'b1;
                     end
                  end
               ST_CALZ:
               begin
                  if (filt_v)
                     last_q <= raw;
                  tmr_q <= tmr_q - 1'b1;
                  if (tmr_q == 32'h0)
                  begin
                     if (kind_q == `ACG_CAL_SELF)
                     begin
                        off_self_q <= {last_q[22:0], 1'b0};
                        moff_q <= last_q;
                        tmr_q <= (SELF_CAL_CYC >> 1) - 1;
                        filt_clr_q <= 1'b1;
                        st_q <= ST_CALF;
                     end
                     else
                     begin
                        off_sys_q <= {last_q[22:0], 1'b0};
                        st_q <= ST_IDLE;
                     end
                  end
               end
               ST_CALF:
               begin
                  if (filt_v)
                     last_q <= raw;
                  tmr_q <= tmr_q - 1'b1;
                  if (tmr_q == 32'h0)
                  begin
                     m_q <= (mdiff[23] | (mdiff == 24'h0)) ? 24'h000001 : mdiff;
                     dq_q <= {`ACG_FS_CODE, 24'h000000};
                     rem_q <= 25'h0;
                     dcnt_q <= 6'h00;
                     st_q <= ST_GDIV;
                  end
               end
               ST_GDIV:
               begin
                  // restoring divide: full scale over measured span, one quotient bit a cycle
                  dq_q <= qfin;
                  rem_q <= dge ? dt - {1'b0, m_q} : dt;
                  dcnt_q <= dcnt_q + 1'b1;
                  if (dcnt_q == 6'd47)
                  begin
                     if (kind_q == `ACG_CAL_SELF)
                        gain_self_q <= gsat;
                     else
                        gain_sys_q <= gsat;
                     st_q <= ST_IDLE;
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end
   assign cal_zero_conn = st_q[2] & (kind_q == `ACG_CAL_SELF);
   assign cal_fs_conn = st_q[3] & (kind_q == `ACG_CAL_SELF);
endmodule

// ### hdl/acg_sinc4.v
// fourth-order sinc decimator for a one-bit modulator stream
// assumes in_en pulses at the modulator rate and dec stays at least 1 between clears
`include "acg_consts.vh"
module acg_sinc4 #(
   parameter ACC_W = 66,
   parameter DEC_W = 16
)(
   input wire mclk,
   input wire rstn,
   input wire clr,
   input wire in_en,
   input wire in_bit,
   input wire [DEC_W-1:0] dec,
   output reg out_valid,
   output reg signed [ACC_W-1:0] out_val
);
   reg signed [ACC_W-1:0] integ [0:3];
   reg signed [ACC_W-1:0] dly [0:3];
   reg signed [ACC_W-1:0] cin [0:3];
   reg signed [ACC_W-1:0] c;
   reg [DEC_W-1:0] cnt_q;
   integer i;
   integer j;
   wire signed [ACC_W-1:0] step = in_bit ? {{(ACC_W-1){1'b0}}, 1'b1} : {ACC_W{1'b1}};

   // comb chain works on the pre-update integrator value at the decimation instant
   always @*
   begin
      c = integ[3];
      for (j = 0; j < 4; j = j + 1)
      begin
         cin[j] = c;
         c = c - dly[j];
      end
   end

   always @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (i = 0; i < 4; i = i + 1)
         begin
            integ[i] <= {ACC_W{1'b0}};
            dly[i] <= {ACC_W{1'b0}};
         end
         cnt_q <= {DEC_W{1'b0}};
         out_valid <= 1'b0;
         out_val <= {ACC_W{1'b0}};
      end
      else
      begin
         out_valid <= 1'b0;
         if (clr)
         begin
            for (i = 0; i < 4; i = i + 1)
            begin
               integ[i] <= {ACC_W{1'b0}};
               dly[i] <= {ACC_W{1'b0}};
            end
            cnt_q <= {DEC_W{1'b0}};
         end
         else if (in_en)
         begin
            integ[0] <= integ[0] + step;
            for (i = 1; i < 4; i = i + 1)
               integ[i] <= integ[i] + integ[i-1];
            if (cnt_q == dec - 1'b1)
            begin
               cnt_q <= {DEC_W{1'b0}};
               for (i = 0; i < 4; i = i + 1)
                  dly[i] <= cin[i];
               out_val <= c;
               out_valid <= 1'b1;
            end
            else
               cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule
